// ---- shared/rlap_defs.vh ----
// register indices, field positions, reset values and geometry
// for the lookup ram access port; definitions only
`ifndef RLAP_DEFS_VH
`define RLAP_DEFS_VH

// register indices; byte address on the bus is four times the index
`define RLAP_IDX_ADDR_CTRL 14'h2887
`define RLAP_IDX_DATA 14'h2888
`define RLAP_IDX_STROBES 14'h2889

// address/control register fields
`define RLAP_PTR_MSB 6
`define RLAP_PTR_LSB 0
`define RLAP_AUTO_BIT 7

// strobe register fields
`define RLAP_RD_BIT 1
`define RLAP_WR_BIT 0

// reset values
`define RLAP_RST_PTR 7'h00
`define RLAP_RST_AUTO 1'b0
`define RLAP_RST_DATA 8'h00
`define RLAP_RST_STROBES 2'h0

// geometry
`define RLAP_PTR_W 7
`define RLAP_DATA_W 8
`define RLAP_RAM_DEPTH 128
`define RLAP_PADDR_W 16

`endif

// ---- design/rlap_lookup_ram.v ----
// lookup ram: 128 bytes of flip-flops, synchronous write and read
// assumes one clock; read data valid the cycle after the address
`timescale 1ns/10ps
`default_nettype none
`include "rlap_defs.vh"

module rlap_lookup_ram (
  // clock
  input wire clk,
  // access port
  input wire en,
  input wire we,
  input wire [`RLAP_PTR_W-1:0] addr,
  input wire [`RLAP_DATA_W-1:0] wdata,
  output reg [`RLAP_DATA_W-1:0] rdata
);

  // storage array, no reset
  reg [`RLAP_DATA_W-1:0] mem [0:`RLAP_RAM_DEPTH-1];

  // write or registered read on enable
  always @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end else begin
        rdata <= mem[addr];
      end
    end
  end

endmodule
`default_nettype wire

// ---- design/rlap_top.v ----
// lookup ram access port: apb slave with pointer, data and strobe regs
// assumes apb master on pclk; all inputs are synchronous to pclk
//
// Summary of operation
// - seven-bit pointer selects the lookup ram location
// - data register carries written or fetched byte
// - auto-advance flag bumps pointer after each strobe
// - reading the pointer shows the advanced value
// - setting read or write strobe starts transfer
// - strobe reads one until transfer finishes
// - pointer advances at finish only if flag set
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "rlap_defs.vh"

module rlap_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb request
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`RLAP_PADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  // apb answer
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);

  // transfer states, one-hot
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ACCESS = 3'b010;
  localparam [2:0] ST_FINISH = 3'b100;

  // byte address of a register from its index
  function [`RLAP_PADDR_W-1:0] byte_addr;
    input [13:0] idx;
    begin
      byte_addr = {idx, 2'b00};
    end
  endfunction

  // software-visible state and the transfer sequencer
  reg [`RLAP_PTR_W-1:0] ptr_reg; // lookup_ram_pointer
  reg auto_reg; // pointer_auto_advance
  reg [`RLAP_DATA_W-1:0] byte_reg; // lookup_ram_byte
  reg rd_strobe_reg; // lookup_read_strobe
  reg wr_strobe_reg; // lookup_write_strobe
  reg [2:0] state_reg; // transfer sequencer
  reg [2:0] state_next;

  // ram side
  wire [`RLAP_DATA_W-1:0] ram_rdata;
  wire ram_en;
  wire ram_we;

  // decode and bus phase
  wire sel_ctrl;
  wire sel_data;
  wire sel_strb;
  wire mapped;
  wire setup;
  wire commit;
  wire busy;
  reg [31:0] rd_mux;

  assign sel_ctrl = (paddr == byte_addr(`RLAP_IDX_ADDR_CTRL));
  assign sel_data = (paddr == byte_addr(`RLAP_IDX_DATA));
  assign sel_strb = (paddr == byte_addr(`RLAP_IDX_STROBES));
  assign mapped = sel_ctrl | sel_data | sel_strb;
  // setup phase of a transfer
  assign setup = psel & ~penable;
  // access edge at which the write lands
  assign commit = psel & penable & pready;
  // a transfer is running while any strobe stands
  assign busy = rd_strobe_reg | wr_strobe_reg;

  // ram is driven only in the access state
  assign ram_en = (state_reg == ST_ACCESS);
  assign ram_we = wr_strobe_reg;

  // lookup storage
  rlap_lookup_ram u_ram (
    .clk(pclk),
    .en(ram_en),
    .we(ram_we),
    .addr(ptr_reg),
    .wdata(byte_reg),
    .rdata(ram_rdata)
  );

  // read data mux, upper bits zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (sel_ctrl) begin
      rd_mux[`RLAP_AUTO_BIT] = auto_reg;
      rd_mux[`RLAP_PTR_MSB:`RLAP_PTR_LSB] = ptr_reg;
    end else if (sel_data) begin
      rd_mux[`RLAP_DATA_W-1:0] = byte_reg;
    end else if (sel_strb) begin
      rd_mux[`RLAP_RD_BIT] = rd_strobe_reg;
      rd_mux[`RLAP_WR_BIT] = wr_strobe_reg;
    end
  end

  // apb answer: ready in the access phase, error if unmapped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end else if (setup) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (busy) begin
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_next = ST_FINISH;
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // pointer and auto-advance flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= `RLAP_RST_PTR;
      auto_reg <= `RLAP_RST_AUTO;
    end else if (state_reg == ST_FINISH) begin
      // advance only when the flag is set, wraps at 127
      if (auto_reg) begin
        ptr_reg <= ptr_reg + 7'h01;
      end
    end else if (commit && pwrite && sel_ctrl && !busy) begin
      // software write, ignored while a transfer runs
      ptr_reg <= pwdata[`RLAP_PTR_MSB:`RLAP_PTR_LSB];
      auto_reg <= pwdata[`RLAP_AUTO_BIT];
    end
  end

  // data byte: fetched byte lands at finish of a read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_reg <= `RLAP_RST_DATA;
    end else if (state_reg == ST_FINISH) begin
      if (rd_strobe_reg) begin
        byte_reg <= ram_rdata;
      end
    end else if (commit && pwrite && sel_data && !busy) begin
      byte_reg <= pwdata[`RLAP_DATA_W-1:0];
    end
  end

  // strobes: set by software when idle, cleared by hardware at finish
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_strobe_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
    end else if (state_reg == ST_FINISH) begin
      rd_strobe_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
    end else if (commit && pwrite && sel_strb && !busy) begin
      // both set at once: write wins, read is dropped
      wr_strobe_reg <= pwdata[`RLAP_WR_BIT];
      rd_strobe_reg <= pwdata[`RLAP_RD_BIT] & ~pwdata[`RLAP_WR_BIT];
    end
  end

endmodule
`default_nettype wire

// ---- verification/rlap_top_asserts.sv ----
// checker on the apb answers of the lookup ram access port
// assumes it is bound to rlap_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module rlap_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup at one address
  sequence s_rd(a);
    psel && !penable && !pwrite && paddr == a;
  endsequence
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  property p_ctl; s_rd(16'hA21C) |=> prdata[31:8] == 24'h0; endproperty
  property p_dat; s_rd(16'hA220) |=> prdata[31:8] == 24'h0; endproperty
  property p_stb; s_rd(16'hA224) |=> prdata[31:2] == 30'h0; endproperty
  property p_bad; s_rd(16'hA230) |=> pslverr && pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_ok; psel && !penable && (paddr == 16'hA21C ||
    paddr == 16'hA220 || paddr == 16'hA224) |=> !pslverr; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  a_ctl: assert property (p_ctl) else $error("pointer wide");
  a_dat: assert property (p_dat) else $error("data wide");
  a_stb: assert property (p_stb) else $error("strobe wide");
  a_bad: assert property (p_bad) else $error("no error");
  a_one: assert property (p_one) else $error("ready held");
  a_ok: assert property (p_ok) else $error("error on mapped");
endmodule
bind rlap_top rlap_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the lookup ram access port
// assumes rlap_top answers apb setups without wait states
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [15:0] ctl = 16'hA21C; // pointer and flag
  localparam logic [15:0] dat = 16'hA220; // data byte
  localparam logic [15:0] stb = 16'hA224; // strobes
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [7:0] mem [0:3]; // bytes written
  logic [6:0] p; // expected pointer
  integer seed, n_fail, checks, i, k;
  rlap_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #2.5 pclk = ~pclk;
  // pointer after a transfer
  function logic [6:0] nxt(input logic [6:0] q, input logic a);
    nxt = a ? q + 7'h01 : q;
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks = checks + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // start a lookup transfer and poll it to the end
  task go(input logic [31:0] c);
    apb(1'b1, stb, c);
    apb(1'b0, stb, 32'h0);
    chk("strobe", rd, c);
    k = 0;
    while (rd !== 32'h0 && k < 8) begin
      apb(1'b0, stb, 32'h0);
      k = k + 1;
    end
    chk("strobe", rd, 32'h0);
  endtask
  task end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    end_of_test;
  end
  initial begin
    seed = 32'h04DF; n_fail = 0; checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      apb(1'b0, ctl + 16'(4 * i), 32'h0);
      chk("reset", rd, 32'h0);
    end
    apb(1'b0, 16'hA230, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    // write four random bytes, pointer wraps 7F to 00
    p = 7'h7E;
    apb(1'b1, ctl, {24'h0, 1'b1, p});
    for (i = 0; i < 4; i++) begin
      mem[i] = 8'($random(seed));
      apb(1'b1, dat, {24'h0, mem[i]});
      go(32'h1);
      p = nxt(p, 1'b1);
    end
    apb(1'b0, ctl, 32'h0);
    chk("pointer", rd, {24'h0, 1'b1, p});
    apb(1'b1, ctl, 32'hFE);
    for (i = 0; i < 4; i++) begin
      go(32'h2);
      apb(1'b0, dat, 32'h0);
      chk("byte", rd, {24'h0, mem[i]});
    end
    // no advance without the flag
    apb(1'b1, ctl, 32'h7F);
    go(32'h2);
    apb(1'b0, dat, 32'h0);
    chk("byte", rd, {24'h0, mem[1]});
    apb(1'b0, ctl, 32'h0);
    chk("pointer", rd, {25'h0, nxt(7'h7F, 1'b0)});
    chk("slverr", {31'h0, er}, 32'h0);
    // both strobes at once: write strobe only
    apb(1'b1, stb, 32'h3);
    apb(1'b0, stb, 32'h0);
    chk("strobe", rd, 32'h1);
    // data write while a transfer runs is dropped
    apb(1'b1, stb, 32'h1);
    apb(1'b1, dat, 32'h5A);
    apb(1'b0, dat, 32'h0);
    chk("byte", rd, {24'h0, mem[1]});
    // reset again in mid-run: every register reads zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      apb(1'b0, ctl + 16'(4 * i), 32'h0);
      chk("reset", rd, 32'h0);
    end
    end_of_test;
  end
endmodule
`default_nettype wire
